// *** verilog/pocl_defines.vh ***
// constants for the proportional output control channel
// assumes a single 100 MHz clock and a synchronous active-low reset
// Functional notes
// - enable response codes 0..5: on/shutoff, on/rampoff, on/keep, off/shutoff/rampoff/keep.
// - unused enable source means the enable signal is always on.
// - active override (0 when input on, 1 when off) forces the override value.
// - faults first, then enable, then override, then control input.
// - control input is normalised to a zero-to-one fraction of its range.
// - target is y = m*x + a; output limits may be inverted.
// - ramp step is output range over ramp time, separate up and down.
// - output type codes: 0 off, 1 current, 2 peak-hold, 3 voltage, 4 on/off, 5 pwm.
// - current mode uses a 25 kHz carrier plus exact-frequency dither of set amplitude.
// - voltage mode scales duty by measured supply to reach target voltage.
// - pwm mode runs at configured frequency, only duty follows control.
// - digital response codes 0 normal, 1 inverse, 2 latched, 3 blinking, digital only.
// - normal is on when commanded on; inverse is on unless commanded on.
// - latched toggles output on every off-to-on command transition.
// - blinking toggles at blink rate while on, off otherwise; on/off type only.
// - on/off mode drives fully on at supply, load current up to 3.5 A.
// - peak-and-hold drives peak current for peak time, then hold current.
// - current types compare feedback with desired current to detect faults.
// - fault response 0 shuts off, 1 applies fault value, 2 holds last value.
// - enabled supply or temperature faults disable the output until cleared; the code disables it only while the synchronised fault pin stays high.
// - after hardware short, drive off and retry every 5 s while still commanded.
// - open load does not interrupt control.
`ifndef POCL_DEFINES_VH
`define POCL_DEFINES_VH
`define POCL_CLK_HZ 32'h05F5_E100
`define POCL_MS_CYCLES 100000
`define POCL_RETRY_MS 5000
`define POCL_CARRIER_HZ 32'h0000_61A8
`define POCL_FRAC_ONE 32'h0001_0000
`define POCL_FRAC_HALF 32'h0000_8000
`define POCL_PERMILLE 32'h0000_03E8
`define POCL_TYPE_OFF 3'h0
`define POCL_TYPE_CUR 3'h1
`define POCL_TYPE_PH 3'h2
`define POCL_TYPE_VOLT 3'h3
`define POCL_TYPE_DIG 3'h4
`define POCL_TYPE_PWM 3'h5
`define POCL_DRESP_NORM 2'h0
`define POCL_DRESP_INV 2'h1
`define POCL_DRESP_LATCH 2'h2
`define POCL_DRESP_BLINK 2'h3
`define POCL_FRESP_OFF 2'h0
`define POCL_FRESP_VALUE 2'h1
`define POCL_FRESP_HOLD 2'h2
`endif

// *** verilog/pocl_output.v ***
// one proportional output channel: command chain, ramp and drive modulator
// assumes feedback words come from an adc on clk; fault pins are asynchronous
`timescale 1ns/100ps
`include "pocl_defines.vh"
module pocl_output #(
  parameter MS_CYCLES = `POCL_MS_CYCLES,
  parameter RETRY_MS = `POCL_RETRY_MS
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // enable and override
  input wire enable_used,
  input wire enable_in,
  input wire [2:0] enable_resp,
  input wire override_used,
  input wire override_in,
  input wire override_resp,
  input wire [15:0] forced_output_value,
  // control and scaling
  input wire [15:0] control_in,
  input wire [15:0] control_min,
  input wire [15:0] control_max,
  input wire [15:0] out_at_min,
  input wire [15:0] out_at_max,
  input wire [15:0] ramp_up_ms,
  input wire [15:0] ramp_down_ms,
  // output type settings
  input wire [2:0] output_type,
  input wire [1:0] digital_resp,
  input wire [15:0] blink_ms,
  input wire [15:0] dither_hz,
  input wire [15:0] dither_amp,
  input wire [15:0] pwm_hz,
  input wire [15:0] peak_current,
  input wire [15:0] hold_current,
  input wire [15:0] peak_ms,
  // fault handling
  input wire fault_detect_en,
  input wire [15:0] fault_tol,
  input wire [1:0] fault_resp,
  input wire [15:0] fault_value,
  input wire fault_clear,
  input wire power_fault_en,
  input wire temp_fault_en,
  input wire supply_bad,
  input wire over_temp,
  // power stage
  input wire [15:0] current_fb,
  input wire [15:0] supply_mv,
  input wire short_shutdown,
  input wire open_load,
  output reg drive_out,
  output reg [15:0] output_level,
  output reg current_fault,
  output reg system_fault,
  output reg short_locked
);

  function [31:0] mul_div;
    input [31:0] a;
    input [31:0] b;
    input [31:0] c;
    reg [63:0] p;
    reg [63:0] q;
    begin
      p = a * b;
      if (c == 32'h0000_0000) begin
        q = 64'h0000_0000_0000_0000;
      end else begin
        q = p / {32'h0000_0000, c};
      end
      mul_div = q[31:0];
    end
  endfunction

  // two-flop synchronisers for the pins
  reg supply_m, supply_s, temp_m, temp_s, short_m, short_s;
  always @(posedge clk) begin
    if (!rstn) begin
      supply_m <= 1'b0;
      supply_s <= 1'b0;
      temp_m <= 1'b0;
      temp_s <= 1'b0;
      short_m <= 1'b0;
      short_s <= 1'b0;
    end else begin
      supply_m <= supply_bad;
      supply_s <= supply_m;
      temp_m <= over_temp;
      temp_s <= temp_m;
      short_m <= short_shutdown;
      short_s <= short_m;
    end
  end

  // millisecond control tick
  reg [31:0] ms_cnt;
  wire tick = (ms_cnt == MS_CYCLES - 1);
  always @(posedge clk) begin
    if (!rstn) ms_cnt <= 32'h0000_0000;
    else if (tick) ms_cnt <= 32'h0000_0000;
    else ms_cnt <= ms_cnt + 32'h0000_0001;
  end

  // normalise and map linearly
  reg [31:0] frac;
  reg [15:0] lin;
  reg [15:0] range_abs;
  reg [31:0] scaled;
  always @* begin
    if (control_in <= control_min) frac = 32'h0000_0000;
    else if (control_in >= control_max) frac = `POCL_FRAC_ONE;
    else frac = mul_div({16'h0000, control_in - control_min}, `POCL_FRAC_ONE,
                        {16'h0000, control_max - control_min});
    if (out_at_max >= out_at_min) begin
      range_abs = out_at_max - out_at_min;
      scaled = mul_div({16'h0000, range_abs}, frac, `POCL_FRAC_ONE);
      lin = out_at_min + scaled[15:0];
    end else begin
      range_abs = out_at_min - out_at_max;
      scaled = mul_div({16'h0000, range_abs}, frac, `POCL_FRAC_ONE);
      lin = out_at_min - scaled[15:0];
    end
  end
  wire [31:0] up_q = mul_div({16'h0000, range_abs}, 32'h0000_0001, {16'h0000, ramp_up_ms});
  wire [31:0] dn_q = mul_div({16'h0000, range_abs}, 32'h0000_0001, {16'h0000, ramp_down_ms});
  // a ramp longer than the range in ms still moves one unit per tick instead of stalling
  wire [15:0] step_up = (ramp_up_ms == 16'h0000) ? range_abs :
                        (up_q == 32'h0000_0000) ? 16'h0001 : up_q[15:0];
  wire [15:0] step_dn = (ramp_down_ms == 16'h0000) ? range_abs :
                        (dn_q == 32'h0000_0000) ? 16'h0001 : dn_q[15:0];

  // digital command shaping
  wire is_dig = (output_type == `POCL_TYPE_PH) || (output_type == `POCL_TYPE_DIG);
  wire cmd_on = (frac >= `POCL_FRAC_HALF);
  reg cmd_prev, latch_q, blink_q, dig_prev;
  reg [15:0] blink_cnt, peak_cnt;
  reg dig_on;
  always @* begin
    case (digital_resp)
      `POCL_DRESP_NORM: dig_on = cmd_on;
      `POCL_DRESP_INV: dig_on = !cmd_on;
      `POCL_DRESP_LATCH: dig_on = latch_q;
      `POCL_DRESP_BLINK: dig_on = (output_type == `POCL_TYPE_DIG) ? (cmd_on & blink_q) : cmd_on;
      default: dig_on = cmd_on;
    endcase
  end
  always @(posedge clk) begin
    if (!rstn) begin
      cmd_prev <= 1'b0;
      latch_q <= 1'b0;
      blink_q <= 1'b0;
      blink_cnt <= 16'h0000;
      dig_prev <= 1'b0;
      peak_cnt <= 16'h0000;
    end else if (tick) begin
      cmd_prev <= cmd_on;
      if (cmd_on && !cmd_prev) latch_q <= !latch_q;
      if (!cmd_on) begin
        blink_q <= 1'b1;
        blink_cnt <= 16'h0000;
      end else if (blink_cnt + 16'h0001 >= blink_ms) begin
        blink_q <= !blink_q;
        blink_cnt <= 16'h0000;
      end else begin
        blink_cnt <= blink_cnt + 16'h0001;
      end
      dig_prev <= dig_on;
      if (dig_on && !dig_prev) peak_cnt <= peak_ms;
      else if (!dig_on) peak_cnt <= 16'h0000;
      else if (peak_cnt != 16'h0000) peak_cnt <= peak_cnt - 16'h0001;
    end
  end
  // peak current for the peak window, hold current after
  wire [15:0] ph_level = (peak_cnt != 16'h0000 || !dig_prev) ? peak_current : hold_current;
  wire [15:0] dig_level = !dig_on ? 16'h0000 :
                          (output_type == `POCL_TYPE_PH) ? ph_level : 16'hFFFF;

  // enable and override decode
  wire en_sig = enable_used ? enable_in : 1'b1;
  wire en_ok = (enable_resp < 3'h3) ? en_sig : !en_sig;
  wire en_shut = (enable_resp == 3'h0) || (enable_resp == 3'h3);
  wire en_ramp = (enable_resp == 3'h1) || (enable_resp == 3'h4);
  wire ov_act = override_used && (override_resp ? !override_in : override_in);
  wire sys_fault = (power_fault_en && supply_s) || (temp_fault_en && temp_s);
  wire is_cur = (output_type == `POCL_TYPE_CUR) || (output_type == `POCL_TYPE_PH);
  wire [15:0] fb_err = (current_fb > output_level) ? current_fb - output_level :
                       output_level - current_fb;
  wire fault_set = fault_detect_en && is_cur && tick && (fb_err > fault_tol);

  // goal selection in priority order, then ramp
  reg [15:0] goal;
  reg jump;
  always @* begin
    goal = output_level;
    jump = 1'b0;
    if (sys_fault) begin
      goal = 16'h0000;
      jump = 1'b1;
    end else if (current_fault) begin
      case (fault_resp)
        `POCL_FRESP_OFF: begin
          goal = 16'h0000;
          jump = 1'b1;
        end
        `POCL_FRESP_VALUE: begin
          goal = fault_value;
          jump = 1'b1;
        end
        default: goal = output_level;
      endcase
    end else if (!en_ok) begin
      if (en_shut) begin
        goal = 16'h0000;
        jump = 1'b1;
      end else if (en_ramp) begin
        goal = 16'h0000;
      end else begin
        goal = output_level;
      end
    end else if (ov_act) begin
      goal = forced_output_value;
      jump = is_dig;
    end else if (is_dig) begin
      goal = dig_level;
      jump = 1'b1;
    end else begin
      goal = lin;
    end
    if (output_type == `POCL_TYPE_OFF) begin
      goal = 16'h0000;
      jump = 1'b1;
    end
  end
  reg [15:0] next_level;
  always @* begin
    if (jump) next_level = goal;
    else if (goal > output_level)
      next_level = (goal - output_level > step_up) ? output_level + step_up : goal;
    else
      next_level = (output_level - goal > step_dn) ? output_level - step_dn : goal;
  end
  always @(posedge clk) begin
    if (!rstn) begin
      output_level <= 16'h0000;
      current_fault <= 1'b0;
      system_fault <= 1'b0;
    end else begin
      system_fault <= sys_fault;
      if (fault_set) current_fault <= 1'b1; // set wins over clear
      else if (fault_clear) current_fault <= 1'b0;
      if (tick) output_level <= next_level;
    end
  end

  // short handling: lock off, retry every RETRY_MS while still wanted
  reg [31:0] retry_cnt;
  always @(posedge clk) begin
    if (!rstn) begin
      short_locked <= 1'b0;
      retry_cnt <= 32'h0000_0000;
    end else if (short_s && !short_locked) begin
      short_locked <= 1'b1;
      retry_cnt <= RETRY_MS;
    end else if (short_locked && tick) begin
      if (retry_cnt > 32'h0000_0001) retry_cnt <= retry_cnt - 32'h0000_0001;
      else if (output_level != 16'h0000) short_locked <= 1'b0;
    end
  end

  // carrier, dither and duty
  reg [31:0] period, per_cnt, duty, duty_i, dith_cnt;
  reg dith_hi;
  wire [31:0] carrier = mul_div(`POCL_CLK_HZ, 32'h0000_0001, `POCL_CARRIER_HZ);
  wire [31:0] next_period = (output_type == `POCL_TYPE_PWM) ?
                            mul_div(`POCL_CLK_HZ, 32'h0000_0001, {16'h0000, pwm_hz}) : carrier;
  wire [31:0] dith_half = mul_div(`POCL_CLK_HZ, 32'h0000_0001, {15'h0000, dither_hz, 1'b0});
  wire [16:0] cur_set = (output_type == `POCL_TYPE_CUR && dith_hi) ? output_level + dither_amp :
                        (output_type == `POCL_TYPE_CUR && output_level > dither_amp) ?
                        {1'b0, output_level - dither_amp} :
                        (output_type == `POCL_TYPE_CUR) ? 17'h0_0000 : {1'b0, output_level};
  reg [31:0] next_duty;
  always @* begin
    case (output_type)
      `POCL_TYPE_CUR, `POCL_TYPE_PH: next_duty = duty_i;
      `POCL_TYPE_VOLT: next_duty = mul_div({16'h0000, output_level}, next_period,
                                           {16'h0000, supply_mv});
      `POCL_TYPE_DIG: next_duty = (output_level != 16'h0000) ? next_period : 32'h0000_0000;
      `POCL_TYPE_PWM: next_duty = mul_div({16'h0000, output_level}, next_period,
                                          `POCL_PERMILLE);
      default: next_duty = 32'h0000_0000;
    endcase
    if (next_duty > next_period) next_duty = next_period;
    // open load leaves the duty untouched
    if (short_locked || sys_fault) next_duty = 32'h0000_0000;
  end
  wire per_end = (per_cnt + 32'h0000_0001 >= period);
  always @(posedge clk) begin
    if (!rstn) begin
      period <= 32'h0000_0001;
      per_cnt <= 32'h0000_0000;
      duty <= 32'h0000_0000;
      duty_i <= 32'h0000_0000;
      dith_cnt <= 32'h0000_0000;
      dith_hi <= 1'b0;
      drive_out <= 1'b0;
    end else begin
      // dither toggles each half period, exact to one clock
      if (dither_hz == 16'h0000) begin
        dith_hi <= 1'b0;
        dith_cnt <= 32'h0000_0000;
      end else if (dith_cnt + 32'h0000_0001 >= dith_half) begin
        dith_hi <= !dith_hi;
        dith_cnt <= 32'h0000_0000;
      end else begin
        dith_cnt <= dith_cnt + 32'h0000_0001;
      end
      if (per_end) begin
        // new duty only at a period edge so no runt pulses appear
        per_cnt <= 32'h0000_0000;
        period <= next_period;
        duty <= next_duty;
        if (!is_cur || cur_set == 17'h0_0000) duty_i <= 32'h0000_0000;
        else if ({1'b0, current_fb} < cur_set && duty_i < period) duty_i <= duty_i + 32'h0000_0001;
        else if ({1'b0, current_fb} > cur_set && duty_i != 32'h0000_0000) duty_i <= duty_i - 32'h0000_0001;
      end else begin
        per_cnt <= per_cnt + 32'h0000_0001;
      end
      drive_out <= (per_cnt < duty) && !short_locked && !sys_fault;
    end
  end

endmodule

// *** bench/pocl_output_sva.sv ***
// checker for one output channel, watching only its ports
// assumes one clock domain and rstn held low for at least two edges
`timescale 1ns/100ps
module pocl_output_sva (
  // clock and reset
  input wire clk,
  input wire rstn,
  // watched inputs
  input wire power_fault_en,
  input wire supply_bad,
  input wire short_shutdown,
  input wire [2:0] output_type,
  input wire enable_used,
  input wire override_used,
  input wire override_in,
  input wire override_resp,
  input wire [15:0] forced_output_value,
  // watched outputs
  input wire drive_out,
  input wire [15:0] output_level,
  input wire current_fault,
  input wire system_fault,
  input wire short_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire clean = !system_fault && !current_fault && !short_locked;
  a_reset_outputs_clear: assert property ($rose(rstn) |-> output_level == 16'h0000
    && !drive_out && !short_locked && !system_fault) else $error("outputs set after reset");
  // level only moves on a control tick, which is far more than 8 cycles apart
  a_level_stands: assert property ($changed(output_level) |=> $stable(output_level)[*8])
    else $error("output level moved between ticks");
  a_supply_fault_set: assert property ((power_fault_en && supply_bad)[*5] |-> system_fault)
    else $error("supply fault not raised");
  a_fault_level_zero: assert property (system_fault && $past(system_fault)
    && $changed(output_level) |-> output_level == 16'h0000) else $error("level nonzero in fault");
  a_short_locks: assert property ($rose(short_shutdown) |-> ##[1:4] short_locked)
    else $error("short did not lock output");
  a_short_quiet: assert property (short_locked[*2] |-> !drive_out)
    else $error("drive while short locked");
  a_type_off_zero: assert property (output_type == 3'h0 && $past(output_type) == 3'h0
    && !override_used && $changed(output_level) |-> output_level == 16'h0000)
    else $error("disabled type gave level");
  a_override_value: assert property (output_type == 3'h4 && override_used && !enable_used
    && (override_in ^ override_resp) && $stable(override_in) && $stable(override_resp)
    && clean && $changed(output_level) |-> output_level == forced_output_value)
    else $error("override value not applied");
  a_digital_full: assert property (output_type == 3'h4 && $stable(output_type)
    && !override_used && clean && $changed(output_level)
    |-> output_level == 16'hFFFF || output_level == 16'h0000) else $error("digital level partial");
endmodule
bind pocl_output pocl_output_sva u_sva (.*);

// *** bench/pocl_load_model.sv ***
// coil load behind a high-side stage: current creeps with drive, supply fixed
// assumes drive_out comes from the channel on the same clock
`timescale 1ns/100ps
module pocl_load_model #(
  parameter SUPPLY = 16'h2EE0
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // stage side
  input wire drive_out,
  output reg [15:0] current_fb = 16'h0000,
  output wire [15:0] supply_mv
);
  assign supply_mv = SUPPLY;
  // inductance: one ma per cycle, so current never jumps with the drive
  always @(posedge clk) begin
    if (!rstn)
      current_fb <= 16'h0000;
    else if (drive_out && current_fb < 16'h0FA0)
      current_fb <= current_fb + 16'h0001;
    else if (!drive_out && current_fb != 16'h0000)
      current_fb <= current_fb - 16'h0001;
  end
endmodule

// *** bench/pocl_output_tb_top.sv ***
// self-checking bench for one output channel with a coil load model
// assumes shortened tick and retry counts; results are sampled after ticks
`timescale 1ns/100ps
module pocl_output_tb_top;
  localparam MS = 100;
  localparam RETRY = 3;
  reg clk, rstn, enable_used, enable_in, override_used, override_in, override_resp;
  reg fault_detect_en, fault_clear, power_fault_en, temp_fault_en, supply_bad, over_temp;
  reg short_shutdown, open_load;
  reg [2:0] enable_resp, output_type;
  reg [1:0] digital_resp, fault_resp;
  reg [15:0] forced_output_value, control_in, control_min, control_max, out_at_min, out_at_max;
  reg [15:0] ramp_up_ms, ramp_down_ms, blink_ms, dither_hz, dither_amp, pwm_hz;
  reg [15:0] peak_current, hold_current, peak_ms, fault_tol, fault_value, v;
  wire [15:0] current_fb, supply_mv, output_level;
  wire drive_out, current_fault, system_fault, short_locked;
  reg [15:0] exp_q[$];
  reg [2:0] sel_q[$];
  string nm[5] = '{"output_level", "short_locked", "system_fault", "current_fault", "drive_out"};
  event sample_ev;
  integer failures = 0, checks = 0, i, n, k;
  pocl_output #(.MS_CYCLES(MS), .RETRY_MS(RETRY)) u_pocl_output (.*);
  pocl_load_model u_pocl_load_model (.clk(clk), .rstn(rstn), .drive_out(drive_out),
    .current_fb(current_fb), .supply_mv(supply_mv));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input string s, input [15:0] seen, input [15:0] e);
    begin
      checks = checks + 1;
      if (seen !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %s expected %h seen %h", s, e, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // the watcher takes the oldest note whenever the driver says a result is due
  always @(sample_ev) begin
    case (sel_q[0])
      3'h0: v = output_level;
      3'h1: v = {15'h0000, short_locked};
      3'h2: v = {15'h0000, system_fault};
      3'h3: v = {15'h0000, current_fault};
      default: v = {15'h0000, drive_out};
    endcase
    check(nm[sel_q.pop_front()], v, exp_q.pop_front());
  end
  task note(input [2:0] s, input [15:0] e);
    begin
      sel_q.push_back(s);
      exp_q.push_back(e);
      -> sample_ev;
      @(negedge clk);
    end
  endtask
  task ticks(input integer t);
    repeat (t * MS + 5) @(negedge clk);
  endtask
  task base;
    begin
      {enable_used, override_used, override_in, override_resp, fault_detect_en} = 5'h00;
      {fault_clear, power_fault_en, temp_fault_en, supply_bad, over_temp} = 5'h00;
      {short_shutdown, open_load, enable_in, enable_resp, digital_resp, fault_resp} = 10'h000;
      {forced_output_value, ramp_up_ms, ramp_down_ms, blink_ms, dither_hz, dither_amp} = 96'h0;
      {pwm_hz, peak_current, hold_current, peak_ms, fault_tol, fault_value} = 96'h0;
      {control_in, control_min, out_at_min} = 48'h0;
      control_max = 16'h03E8;
      out_at_max = 16'h03E8;
      output_type = 3'h4;
    end
  endtask
  initial begin
    rstn = 1'b0;
    base;
    k = $urandom(76040);
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    digital_resp = 2'h2;
    control_in = 16'h01F4;
    ticks(2);
    note(0, 16'hFFFF);
    control_in = 16'h0000;
    ticks(2);
    note(0, 16'hFFFF);
    control_in = 16'h01F4;
    ticks(2);
    note(0, 16'h0000);
    $display("latched test done");
    for (i = 0; i < 2; i = i + 1) begin
      digital_resp = i[1:0];
      control_in = 16'h01F4;
      ticks(2);
      note(0, i ? 16'h0000 : 16'hFFFF);
      control_in = 16'h01F3;
      ticks(2);
      note(0, i ? 16'hFFFF : 16'h0000);
    end
    $display("normal and inverse test done");
    digital_resp = 2'h0;
    control_in = 16'h03E8;
    enable_used = 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      enable_resp = i[2:0];
      enable_in = (i < 3);
      ticks(2);
      note(0, 16'hFFFF);
      if (i % 3 != 1) begin
        enable_in = ~enable_in;
        ticks(2);
        note(0, (i % 3) ? 16'hFFFF : 16'h0000);
      end
    end
    enable_resp = 3'h0;
    enable_in = 1'b0;
    enable_used = 1'b0;
    ticks(2);
    note(0, 16'hFFFF);
    $display("enable test done");
    control_in = 16'h0000;
    override_used = 1'b1;
    forced_output_value = 16'h1234;
    for (i = 0; i < 3; i = i + 1) begin
      override_resp = (i > 0);
      override_in = (i != 1);
      ticks(2);
      note(0, i == 2 ? 16'h0000 : 16'h1234);
    end
    override_in = 1'b0;
    power_fault_en = 1'b1;
    supply_bad = 1'b1;
    ticks(2);
    note(2, 16'h0001);
    note(0, 16'h0000);
    base;
    $display("override and fault order test done");
    output_type = 3'h3;
    {out_at_min, out_at_max} = {16'h03E8, 16'h0000};
    for (i = 0; i < 3; i = i + 1) begin
      k = $urandom % 9;
      control_in = 16'h007D * k[15:0];
      ticks(2);
      note(0, 16'h03E8 - 16'h007D * k[15:0]);
    end
    {out_at_min, out_at_max, control_in} = {16'h0000, 16'h03E8, 16'h0000};
    ticks(2);
    {ramp_up_ms, ramp_down_ms, control_in} = {16'h000A, 16'h0001, 16'h03E8};
    for (n = 0; n < MS + 10 && output_level === 16'h0000; n = n + 1)
      @(negedge clk);
    if (n == MS + 10) begin
      failures = failures + 1;
      tally_and_finish;
    end
    note(0, 16'h0064);
    repeat (MS - 1) @(negedge clk);
    note(0, 16'h00C8);
    $display("mapping and ramp test done");
    base;
    output_type = 3'h1;
    {control_in, fault_detect_en, fault_tol} = {16'h03E8, 1'b1, 16'h0010};
    {fault_resp, fault_value, open_load} = {2'h1, 16'h0055, 1'b1};
    ticks(3);
    note(3, 16'h0001);
    note(0, 16'h0055);
    fault_resp = 2'h0;
    ticks(2);
    note(0, 16'h0000);
    {fault_clear, fault_detect_en} = 2'b10;
    ticks(2);
    note(3, 16'h0000);
    base;
    control_in = 16'h01F4;
    ticks(41);
    note(4, 16'h0001);
    short_shutdown = 1'b1;
    repeat (10) @(negedge clk);
    note(1, 16'h0001);
    note(4, 16'h0000);
    short_shutdown = 1'b0;
    ticks(RETRY + 2);
    note(1, 16'h0000);
    output_type = 3'h0;
    ticks(2);
    note(0, 16'h0000);
    $display("current fault and short test done");
    tally_and_finish;
  end
endmodule
